// ---- bpsc_regs.sv ----
// How it works
// - The capability-list flag at status bit 20 reads 1 from reset onward.
// - The 66 MHz flag (bit 21) and fast back-to-back flag (bit 23) are read-only and read 0.
// - Bit 24 is set only with parity response enabled on a received poisoned completion or a poisoned write sent.
// - The select-timing field at bits 26:25 is read-only and always reads 00.
// - Bit 27 is set when the block finishes a primary request with completer-abort status.
// - Bit 28 is set when a completion with completer-abort status is received.
// - Bit 29 is set when a completion with unsupported-request status is received.
// - Bit 30 is set whenever a fatal or non-fatal error message is sent on the primary link.
// - Bit 31 is set on any poisoned packet detected, whatever the parity response enable.
// - The programming-interface byte reads 00h with the legacy bit clear and 01h with it set.
// - The sub-class byte is the constant 04h and read-only.
// - The base-class byte is the constant 06h and read-only.
// - Command bit 6 is the parity response enable that gates the bit 24 flag.
`timescale 1ns/100ps
`include "bpsc_defs.svh"
module bpsc_regs #(
  parameter int         ADDR_W = `BPSC_ADDR_W,
  parameter logic [7:0] REV_ID = 8'h5a   // Value is arbitrary
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              evt_poisoned_cpl_rx,
  input  wire logic              evt_poisoned_wr_tx,
  input  wire logic              evt_ca_cpl_sent,
  input  wire logic              evt_ca_cpl_rx,
  input  wire logic              evt_ur_cpl_rx,
  input  wire logic              evt_err_msg_tx,
  input  wire logic              evt_poisoned_tlp_rx,
  output logic                   parity_resp_en,
  output logic                   legacy_mode,
  output logic                   irq
);
  // Narrower buses could not reach the interrupt registers
  if (ADDR_W < `BPSC_ADDR_W) begin : g_addr_w_check
    $error("ADDR_W too small for the register map");
  end

  logic                  setup_stb;
  logic                  done_stb;
  logic                  wr_done;
  logic                  hit_cmdsts;
  logic                  hit_class;
  logic                  hit_legacy;
  logic                  hit_ists;
  logic                  hit_iclr;
  logic                  hit_ien;
  logic                  hit_any;
  bpsc_pkg::bpsc_flags_t evt;
  bpsc_pkg::bpsc_flags_t sts;
  bpsc_pkg::bpsc_flags_t sts_clr;
  bpsc_pkg::bpsc_flags_t ists;
  bpsc_pkg::bpsc_flags_t ists_clr;
  bpsc_pkg::bpsc_flags_t ien;
  bpsc_pkg::bpsc_flags_t next_ien;
  logic                  next_perr_en;
  logic                  next_legacy;
  logic                  next_irq;
  bpsc_pkg::bpsc_word_t  rd_cmdsts;
  bpsc_pkg::bpsc_word_t  rd_class;
  bpsc_pkg::bpsc_word_t  rd_mux;
  bpsc_pkg::bpsc_word_t  next_prdata;
  logic                  next_pslverr;

  bpsc_apb_front u_front (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pready    (pready),
    .setup_stb (setup_stb),
    .done_stb  (done_stb)
  );

  // Upper address bits must be zero so the map does not alias
  assign hit_any    = (paddr[ADDR_W-1:0] >> `BPSC_ADDR_W) == '0;
  assign hit_cmdsts = hit_any && paddr[`BPSC_ADDR_W-1:0] == `BPSC_OFF_CMDSTS;
  assign hit_class  = hit_any && paddr[`BPSC_ADDR_W-1:0] == `BPSC_OFF_CLASS;
  assign hit_legacy = hit_any && paddr[`BPSC_ADDR_W-1:0] == `BPSC_OFF_LEGACY;
  assign hit_ists   = hit_any && paddr[`BPSC_ADDR_W-1:0] == `BPSC_OFF_ISTS;
  assign hit_iclr   = hit_any && paddr[`BPSC_ADDR_W-1:0] == `BPSC_OFF_ICLR;
  assign hit_ien    = hit_any && paddr[`BPSC_ADDR_W-1:0] == `BPSC_OFF_IEN;
  assign wr_done    = done_stb && pwrite;

  // Flag order: 0 bit24, 1 bit27, 2 bit28, 3 bit29, 4 bit30, 5 bit31
  assign evt[0] = parity_resp_en && (evt_poisoned_cpl_rx || evt_poisoned_wr_tx);
  assign evt[1] = evt_ca_cpl_sent;
  assign evt[2] = evt_ca_cpl_rx;
  assign evt[3] = evt_ur_cpl_rx;
  assign evt[4] = evt_err_msg_tx;
  // A poisoned completion is itself a poisoned packet
  assign evt[5] = evt_poisoned_tlp_rx || evt_poisoned_cpl_rx;

  // Only ones written with the top byte lane enabled clear a status flag, and with the low byte lane an interrupt flag
  always_comb begin
    sts_clr  = '0;
    ists_clr = '0;
    if (wr_done && hit_cmdsts && pstrb[3]) begin
      sts_clr = {pwdata[`BPSC_BIT_DPE:`BPSC_BIT_STA], pwdata[`BPSC_BIT_MDPE]};
    end
    if (wr_done && hit_iclr && pstrb[0]) begin
      ists_clr = pwdata[`BPSC_NFLAG-1:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `BPSC_NFLAG; gi++) begin : g_flag
      bpsc_w1c_flag u_sts (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (evt[gi]),
        .clr     (sts_clr[gi]),
        .q       (sts[gi])
      );
      bpsc_w1c_flag u_ists (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (evt[gi]),
        .clr     (ists_clr[gi]),
        .q       (ists[gi])
      );
    end
  endgenerate

  // Writable control bits
  always_comb begin
    next_perr_en = parity_resp_en;
    next_legacy  = legacy_mode;
    next_ien     = ien;
    if (wr_done && hit_cmdsts && pstrb[0]) begin
      next_perr_en = pwdata[`BPSC_BIT_PERR_EN];
    end
    if (wr_done && hit_legacy && pstrb[0]) begin
      next_legacy = pwdata[`BPSC_BIT_LEGACY];
    end
    if (wr_done && hit_ien && pstrb[0]) begin
      next_ien = pwdata[`BPSC_NFLAG-1:0];
    end
  end

  // Read-only fields are built from constants or from legacy_mode, so writes to them cannot reach them
  always_comb begin
    rd_cmdsts                       = '0;
    rd_cmdsts[`BPSC_BIT_PERR_EN]    = parity_resp_en;
    rd_cmdsts[`BPSC_BIT_CAPL]       = `BPSC_CAPL_VAL;
    rd_cmdsts[`BPSC_BIT_M66]        = `BPSC_M66_VAL;
    rd_cmdsts[`BPSC_BIT_FB2B]       = `BPSC_FB2B_VAL;
    rd_cmdsts[`BPSC_BIT_MDPE]       = sts[0];
    rd_cmdsts[26:25]                = `BPSC_DEVT_VAL;
    rd_cmdsts[`BPSC_BIT_STA]        = sts[1];
    rd_cmdsts[`BPSC_BIT_RTA]        = sts[2];
    rd_cmdsts[`BPSC_BIT_RMA]        = sts[3];
    rd_cmdsts[`BPSC_BIT_SSE]        = sts[4];
    rd_cmdsts[`BPSC_BIT_DPE]        = sts[5];
    rd_class[7:0]                   = REV_ID;
    rd_class[15:8]  = legacy_mode ? `BPSC_PI_LEGACY : `BPSC_PI_NORMAL;
    rd_class[23:16]                 = `BPSC_SUBCLASS;
    rd_class[31:24]                 = `BPSC_BASECLASS;
  end

  always_comb begin
    rd_mux       = '0;
    next_pslverr = 1'b0;
    if (hit_cmdsts) begin
      rd_mux = rd_cmdsts;
    end else if (hit_class) begin
      rd_mux = rd_class;
    end else if (hit_legacy) begin
      rd_mux = {31'h0, legacy_mode};
    end else if (hit_ists) begin
      rd_mux = {26'h0, ists};
    end else if (hit_ien) begin
      rd_mux = {26'h0, ien};
    end else if (!hit_iclr) begin
      next_pslverr = 1'b1;
    end
    next_prdata = (pwrite || next_pslverr) ? '0 : rd_mux;
  end

  // Read data is captured in setup, held stable through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup_stb) begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end else if (done_stb) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
  end

  assign next_irq = |(ists & ien);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_resp_en <= `BPSC_CTRL_RST;
      legacy_mode    <= `BPSC_CTRL_RST;
      ien            <= '0;
      irq            <= 1'b0;
    end else begin
      parity_resp_en <= next_perr_en;
      legacy_mode    <= next_legacy;
      ien            <= next_ien;
      irq            <= next_irq;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_cmdsts_done;
  logic rd_class_done;
  assign rd_cmdsts_done = done_stb && !pwrite && hit_cmdsts;
  assign rd_class_done  = done_stb && !pwrite && hit_class;

  // Checks restate the decode so they do not lean on the logic they watch
  logic err_msg_one_wr;
  logic irq_due;
  logic hit_mapped;
  assign err_msg_one_wr = wr_done && hit_cmdsts && pstrb[3] && pwdata[`BPSC_BIT_SSE];
  assign irq_due        = |(ists & ien);
  assign hit_mapped     = hit_cmdsts || hit_class || hit_legacy || hit_ists || hit_iclr || hit_ien;

  capl_reads_one_a: assert property (rd_cmdsts_done |-> prdata[`BPSC_BIT_CAPL])
    else $error("capability flag did not read 1");
  ro_caps_zero_a: assert property (rd_cmdsts_done |-> !prdata[`BPSC_BIT_M66] && !prdata[`BPSC_BIT_FB2B])
    else $error("66 MHz or back-to-back flag read 1");
  timing_rsvd_zero_a: assert property (rd_cmdsts_done |-> prdata[26:25] == 2'h0 && prdata[22] == 1'b0
                                       && prdata[19:16] == 4'h0)
    else $error("select timing or reserved bits not zero");
  mdpe_gated_a: assert property ($rose(sts[0]) |-> $past(parity_resp_en))
    else $error("bit 24 set without parity response enable");
  mdpe_set_a: assert property (parity_resp_en && evt_poisoned_wr_tx |=> sts[0])
    else $error("bit 24 not set on poisoned write");
  abort_flags_a: assert property (evt_ca_cpl_sent ##1 1'b1 |-> sts[1] ##0 rd_cmdsts[`BPSC_BIT_STA])
    else $error("bit 27 not set");
  rta_set_a: assert property (evt_ca_cpl_rx |=> sts[2])
    else $error("bit 28 not set");
  rma_set_a: assert property (evt_ur_cpl_rx |=> sts[3])
    else $error("bit 29 not set");
  sse_set_a: assert property (evt_err_msg_tx |=> sts[4])
    else $error("bit 30 not set");
  dpe_any_a: assert property (!parity_resp_en && evt_poisoned_tlp_rx |=> sts[5] && !$rose(sts[0]))
    else $error("bit 31 not set regardless of enable");
  prog_if_a: assert property (rd_class_done |-> prdata[15:8] == {7'h0, $past(legacy_mode)})
    else $error("programming interface byte wrong");
  class_const_a: assert property (rd_class_done |-> prdata[31:16] == 16'h0604)
    else $error("class bytes wrong");
  w1c_only_a: assert property ($fell(sts[4]) |-> $past(err_msg_one_wr))
    else $error("status flag cleared without a one written");
  irq_follow_a: assert property (##1 irq == $past(irq_due))
    else $error("interrupt does not follow enabled status");

  parity_clr_a: assert property ($fell(sts[0]) |-> $past(wr_done) && $past(pwdata[`BPSC_BIT_MDPE]))
    else $error("bit 24 cleared without a one written");
  sent_abort_clr_a: assert property ($fell(sts[1]) |-> $past(wr_done) && $past(pwdata[`BPSC_BIT_STA]))
    else $error("bit 27 cleared without a one written");
  rx_abort_clr_a: assert property ($fell(sts[2]) |-> $past(wr_done) && $past(pwdata[`BPSC_BIT_RTA]))
    else $error("bit 28 cleared without a one written");
  ur_clr_a: assert property ($fell(sts[3]) |-> $past(wr_done) && $past(pwdata[`BPSC_BIT_RMA]))
    else $error("bit 29 cleared without a one written");
  poison_clr_a: assert property ($fell(sts[5]) |-> $past(wr_done) && $past(pwdata[`BPSC_BIT_DPE]))
    else $error("bit 31 cleared without a one written");
  set_wins_a: assert property (evt[1] && sts_clr[1] |=> sts[1])
    else $error("clear beat a same-cycle event");
  ists_sets_a: assert property (evt_ca_cpl_rx |=> ists[2] && sts[2])
    else $error("event did not set both status copies");
  perr_en_wr_a: assert property (wr_done && hit_cmdsts && pstrb[0]
                                 |=> parity_resp_en == $past(pwdata[`BPSC_BIT_PERR_EN]))
    else $error("parity response enable not written");
  perr_en_hold_a: assert property (!(wr_done && hit_cmdsts && pstrb[0]) |=> $stable(parity_resp_en))
    else $error("parity response enable changed without a write");
  legacy_wr_a: assert property (wr_done && hit_legacy && pstrb[0]
                                |=> legacy_mode == $past(pwdata[`BPSC_BIT_LEGACY]))
    else $error("legacy bit not written");
  ien_wr_a: assert property (wr_done && hit_ien && pstrb[0]
                             |=> ien == $past(pwdata[`BPSC_NFLAG-1:0]))
    else $error("interrupt enable not written");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  prdata_idle_a: assert property (!pready |-> prdata == '0 && !pslverr)
    else $error("read data or error outside the access phase");
  unmapped_err_a: assert property (setup_stb && !hit_mapped |=> pslverr && prdata == '0)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (setup_stb && hit_mapped |=> !pslverr)
    else $error("error on a mapped access");
  rd_write_zero_a: assert property (setup_stb && pwrite |=> prdata == '0)
    else $error("read data shown during a write");

  rd_status_c: cover property (rd_cmdsts_done && prdata[`BPSC_BIT_DPE]);
  clr_flag_c: cover property (sts[2] ##1 !sts[2]);
  set_clr_same_c: cover property (evt[1] && sts_clr[1]);
  irq_rise_c: cover property ($rose(irq));
  unmapped_c: cover property (setup_stb && !hit_mapped);
endmodule : bpsc_regs

// ---- bpsc_defs.svh ----
`ifndef BPSC_DEFS_SVH
`define BPSC_DEFS_SVH
// Byte offsets on the register bus
`define BPSC_OFF_CMDSTS  12'h004
`define BPSC_OFF_CLASS   12'h008
`define BPSC_OFF_LEGACY  12'h098
`define BPSC_OFF_ISTS    12'h100
`define BPSC_OFF_ICLR    12'h104
`define BPSC_OFF_IEN     12'h108
`define BPSC_ADDR_W      12
// Field positions in the command/status word and the legacy register
`define BPSC_BIT_PERR_EN 6
`define BPSC_BIT_CAPL    20
`define BPSC_BIT_M66     21
`define BPSC_BIT_FB2B    23
`define BPSC_BIT_MDPE    24
`define BPSC_BIT_STA     27
`define BPSC_BIT_RTA     28
`define BPSC_BIT_RMA     29
`define BPSC_BIT_SSE     30
`define BPSC_BIT_DPE     31
`define BPSC_BIT_LEGACY  0
// Constant and reset values
`define BPSC_CAPL_VAL    1'b1
`define BPSC_M66_VAL     1'b0
`define BPSC_FB2B_VAL    1'b0
`define BPSC_DEVT_VAL    2'h0
`define BPSC_SUBCLASS    8'h04
`define BPSC_BASECLASS   8'h06
`define BPSC_PI_LEGACY   8'h01
`define BPSC_PI_NORMAL   8'h00
`define BPSC_FLAG_RST    1'b0
`define BPSC_CTRL_RST    1'b0
`define BPSC_NFLAG       6
`endif

// ---- bpsc_pkg.sv ----
package bpsc_pkg;
  typedef enum logic [1:0] {
    BPSC_IDLE   = 2'b01,
    BPSC_ACCESS = 2'b10
  } bpsc_apb_e;
  typedef logic [31:0] bpsc_word_t;
  typedef logic [5:0]  bpsc_flags_t;
endpackage : bpsc_pkg

// ---- bpsc_w1c_flag.sv ----
`timescale 1ns/100ps
`include "bpsc_defs.svh"
module bpsc_w1c_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);
  logic next_q;

  // Set beats clear so an event in the clearing cycle survives
  always_comb begin
    next_q = q;
    if (clr) begin
      next_q = 1'b0;
    end
    if (set) begin
      next_q = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= `BPSC_FLAG_RST;
    end else begin
      q <= next_q;
    end
  end
endmodule : bpsc_w1c_flag

// ---- bpsc_apb_front.sv ----
`timescale 1ns/100ps
module bpsc_apb_front (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic psel,
  input  wire logic penable,
  output logic      pready,
  output logic      setup_stb,
  output logic      done_stb
);
  bpsc_pkg::bpsc_apb_e state;
  bpsc_pkg::bpsc_apb_e next_state;
  logic                next_pready;

  // Zero wait states: pready is raised for the whole access phase
  always_comb begin
    next_state  = state;
    next_pready = pready;
    setup_stb   = 1'b0;
    done_stb    = 1'b0;
    case (state)
      bpsc_pkg::BPSC_IDLE: begin
        if (psel && !penable) begin
          setup_stb   = 1'b1;
          next_state  = bpsc_pkg::BPSC_ACCESS;
          next_pready = 1'b1;
        end
      end
      bpsc_pkg::BPSC_ACCESS: begin
        if (psel && penable) begin
          done_stb    = 1'b1;
          next_state  = bpsc_pkg::BPSC_IDLE;
          next_pready = 1'b0;
        end
      end
      default: begin
        next_state  = bpsc_pkg::BPSC_IDLE;
        next_pready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= bpsc_pkg::BPSC_IDLE;
      pready <= 1'b0;
    end else begin
      state  <= next_state;
      pready <= next_pready;
    end
  end
endmodule : bpsc_apb_front

// ---- bpsc_host_model.sv ----
`timescale 1ns/100ps
module bpsc_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rdata;
  logic        rerr;
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
  end
  // Holds the request until pready; the bench timeout ends a hang
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask : xfer
endmodule : bpsc_host_model

// ---- bridge_primary_status_class_regs_tb_top.sv ----
`timescale 1ns/100ps
`include "bpsc_defs.svh"
module bridge_primary_status_class_regs_tb_top;
  localparam logic [7:0] REV = 8'h3c;   // Value is arbitrary
  logic        pclk;
  logic        presetn;
  logic [6:0]  evt;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        parity_resp_en;
  logic        legacy_mode;
  logic        irq;
  int          n_errors;
  int          tests_run;
  int          cyc;
  int          k;
  logic        pe;
  logic [31:0] m;

  bpsc_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  bpsc_regs #(.REV_ID(REV)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt_poisoned_cpl_rx(evt[0]), .evt_poisoned_wr_tx(evt[1]),
    .evt_ca_cpl_sent(evt[2]), .evt_ca_cpl_rx(evt[3]), .evt_ur_cpl_rx(evt[4]), .evt_err_msg_tx(evt[5]),
    .evt_poisoned_tlp_rx(evt[6]), .parity_resp_en(parity_resp_en), .legacy_mode(legacy_mode), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
    host.xfer(1'b0, a, 32'h0, 4'hf);
    chk(host.rdata, exp);
    chk({31'h0, host.rerr}, {31'h0, e});
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    host.xfer(1'b1, a, d, s);
  endtask : wr

  // Status bits that an event class must set, given the parity response enable
  function automatic logic [31:0] ev_mask(input int n, input logic en);
    logic [31:0] t [7];
    t = '{32'h8000_0000, 32'h0, 32'h0800_0000, 32'h1000_0000, 32'h2000_0000, 32'h4000_0000, 32'h8000_0000};
    ev_mask = t[n] | ((n < 2 && en) ? 32'h0100_0000 : 32'h0);
  endfunction : ev_mask

  function automatic logic [31:0] int_bits(input logic [31:0] s);
    int_bits = {26'h0, s[31], s[30], s[29], s[28], s[27], s[24]};
  endfunction : int_bits

  task automatic pulse(input int n);
    @(posedge pclk);
    evt[n] <= 1'b1;
    @(posedge pclk);
    evt <= 7'h00;
  endtask : pulse

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    presetn   = 1'b0;
    evt       = 7'h00;
    n_errors  = 0;
    tests_run = 0;
    cyc       = 0;
    void'($urandom(32'hb05d));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`BPSC_OFF_CMDSTS, 32'h0010_0000, 1'b0);
    rd(`BPSC_OFF_CLASS, {8'h06, 8'h04, 8'h00, REV}, 1'b0);
    // Writes of all ones hit only the enable; read-only fields hold
    wr(`BPSC_OFF_CMDSTS, 32'hffff_ffff, 4'hf);
    rd(`BPSC_OFF_CMDSTS, 32'h0010_0040, 1'b0);
    chk({31'h0, parity_resp_en}, 32'h1);
    wr(`BPSC_OFF_CLASS, 32'hffff_ffff, 4'hf);
    rd(`BPSC_OFF_CLASS, {8'h06, 8'h04, 8'h00, REV}, 1'b0);
    wr(`BPSC_OFF_LEGACY, 32'h1, 4'hf);
    rd(`BPSC_OFF_CLASS, {8'h06, 8'h04, 8'h01, REV}, 1'b0);
    chk({31'h0, legacy_mode}, 32'h1);
    wr(`BPSC_OFF_LEGACY, 32'h0, 4'hf);
    rd(`BPSC_OFF_CLASS, {8'h06, 8'h04, 8'h00, REV}, 1'b0);
    rd(12'h00c, 32'h0, 1'b1);
    rd(`BPSC_OFF_ICLR, 32'h0, 1'b0);
    // Every event class with the enable set, then 14 random classes with random enable
    for (int i = 0; i < 21; i++) begin
      k  = (i < 7) ? i : int'($urandom % 7);
      pe = (i < 7) ? 1'b1 : 1'($urandom % 2);
      wr(`BPSC_OFF_CMDSTS, {25'h0, pe, 6'h0}, 4'h1);
      wr(`BPSC_OFF_ICLR, 32'h3f, 4'hf);
      pulse(k);
      m = ev_mask(k, pe);
      rd(`BPSC_OFF_CMDSTS, m | 32'h0010_0000 | {25'h0, pe, 6'h0}, 1'b0);
      rd(`BPSC_OFF_ISTS, int_bits(m), 1'b0);
      // Zero writes leave the flags; set lanes without strobe do nothing
      wr(`BPSC_OFF_CMDSTS, {25'h0, pe, 6'h0}, 4'hf);
      rd(`BPSC_OFF_CMDSTS, m | 32'h0010_0000 | {25'h0, pe, 6'h0}, 1'b0);
      wr(`BPSC_OFF_CMDSTS, 32'hff00_0000 | {25'h0, pe, 6'h0}, 4'h7);
      rd(`BPSC_OFF_CMDSTS, m | 32'h0010_0000 | {25'h0, pe, 6'h0}, 1'b0);
      wr(`BPSC_OFF_CMDSTS, 32'hff00_0000 | {25'h0, pe, 6'h0}, 4'hf);
      rd(`BPSC_OFF_CMDSTS, 32'h0010_0000 | {25'h0, pe, 6'h0}, 1'b0);
    end
    // Parity enable off: poisoned write sent sets nothing
    wr(`BPSC_OFF_CMDSTS, 32'h0, 4'hf);
    pulse(1);
    rd(`BPSC_OFF_CMDSTS, 32'h0010_0000, 1'b0);
    // Interrupt: raised masked, enabled, cleared
    wr(`BPSC_OFF_ICLR, 32'h3f, 4'hf);
    pulse(3);
    repeat (3) @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    wr(`BPSC_OFF_IEN, 32'h3f, 4'hf);
    rd(`BPSC_OFF_IEN, 32'h3f, 1'b0);
    @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr(`BPSC_OFF_ICLR, 32'h4, 4'hf);
    repeat (2) @(posedge pclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    rd(`BPSC_OFF_ISTS, 32'h0, 1'b0);
    rd(`BPSC_OFF_CMDSTS, 32'h1010_0000, 1'b0);
    stop_test();
  end
endmodule : bridge_primary_status_class_regs_tb_top
